// File: ccf_cam_model.sv
// Camera processor model: pixel clock, syncs and pixel bytes.
// Pixel clock stands still between frames; idle bus shows inverted data.
`timescale 1ns/100ps
`default_nettype none
module ccf_cam_model (
  output logic cam_pixel_clock,
  output logic cam_frame_sync,
  output logic cam_line_valid,
  output logic [7:0] cam_pixel_bus
);
  initial begin
    cam_pixel_clock = 1'b0;
    cam_frame_sync = 1'b1;
    cam_line_valid = 1'b0;
    cam_pixel_bus = 8'h5A;
  end
  // One byte per 400 ns period, changed with the falling clock
  task automatic put(input logic [7:0] b);
    cam_pixel_bus = b;
    #200 cam_pixel_clock = 1'b1;
    #200 cam_pixel_clock = 1'b0;
  endtask
  // Reference code for field one with its protection bits
  task automatic code(input logic v, input logic h);
    put(8'hFF);
    put(8'h00);
    put(8'h00);
    put({1'b1, 1'b0, v, h, v ^ h, h, v, v ^ h});
  endtask
  task automatic frame(input logic emb, input logic inv_lv);
    cam_line_valid = inv_lv;
    if (emb) begin
      code(1'b1, 1'b1);
      code(1'b0, 1'b0);
    end else begin
      put(8'h00);
      cam_frame_sync = 1'b0;
      put(8'h00);
      cam_line_valid = !inv_lv;
    end
    for (int i = 0; i < 8; i++) begin
      put(8'h10 + 8'(i));
    end
    cam_line_valid = inv_lv;
    if (emb) begin
      code(1'b0, 1'b1);
      code(1'b1, 1'b1);
    end else begin
      put(8'h00);
      cam_frame_sync = 1'b1;
      put(8'h00);
    end
    cam_pixel_bus = ~cam_pixel_bus;
  endtask
endmodule
`default_nettype wire

// File: ccf_capture_sva.sv
// Port-level checker for the capture front end.
// Bound to ccf_capture_top; sees only its ports, all on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module ccf_capture_chk (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic frame_irq,
  input wire logic cam_master_clock_out,
  input wire logic cam_reset_out,
  input wire logic prv_wr_valid,
  input wire logic [12:0] prv_wr_x,
  input wire logic [12:0] prv_wr_y,
  input wire logic cod_wr_valid,
  input wire logic [1:0] cod_wr_plane,
  input wire logic [12:0] cod_wr_x,
  input wire logic [12:0] cod_wr_y
);
  import ccf_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside its slot");
  a_irq_pulse: assert property (frame_irq |=> !frame_irq)
    else $error("frame interrupt longer than one cycle");
  a_cod_pulse: assert property (cod_wr_valid |=> !cod_wr_valid)
    else $error("codec word strobe longer than one cycle");
  a_cod_plane: assert property (cod_wr_valid |-> cod_wr_plane < 2'h3)
    else $error("codec word on a fourth plane");
  a_prv_bounds: assert property (prv_wr_valid |->
    prv_wr_x < PRV_MAX_W && prv_wr_y < PRV_MAX_H)
    else $error("preview word outside 640x480");
  a_cod_bounds: assert property (cod_wr_valid |->
    cod_wr_x < MAX_IN && cod_wr_y < MAX_IN)
    else $error("codec word outside 4096 square");
  a_mclk_div: assert property ($rose(cam_master_clock_out) |=>
    cam_master_clock_out ##1 !cam_master_clock_out [*2] ##1
    cam_master_clock_out)
    else $error("camera master clock not ref_clk by four");
  // The camera reset pin only moves after a register write
  a_camrst_src: assert property ($changed(cam_reset_out) |->
    $past(reg_wr) || $past(reg_wr, 2))
    else $error("camera reset pin moved without a write");
endmodule
bind ccf_capture_top ccf_capture_chk i_ccf_capture_chk (.ref_clk, .rstn,
  .reg_wr, .reg_rd, .reg_rdata, .frame_irq, .cam_master_clock_out,
  .cam_reset_out, .prv_wr_valid, .prv_wr_x, .prv_wr_y, .cod_wr_valid,
  .cod_wr_plane, .cod_wr_x, .cod_wr_y);
`default_nettype wire

// File: ccf_capture_top.sv
// Camera capture front end: pin sampling, sync decode, command latch,
// preview and codec word streams. Assumes ref_clk well above pixel rate.
//
// Notes on behaviour
// - FF 00 00 preamble starts a reference code
// - H flag 0 opens, 1 closes active video
// - V flag high means field blanking, frame sync
// - F flag selects first or second field
// - Code word: one, F, V, H, protection
// - Input up to 4096 square, 2048 scaled
// - Preview max 640x480, codec up to 4096
// - Programmable polarity of clock and syncs
// - Pixel and bus timing kept unrelated
// - Separate preview RGB and codec YCbCr paths
// - Four rotating buffers, codec has three planes
// - Codec words little-endian, earliest byte low
// - RGB24 one pixel, RGB16 two per word
// - Commands take effect at frame sync fall
// - Frame sync level readable in status
// - X mirror, Y mirror or 180 rotation
// - Frame interrupt at start, last at end
// - Last-frame enable clears itself after use
// - Frame counter steps 0 to 3 per interrupt
// - Codec overflow when preview runs alone
// - Mode bit 31: 1 separate syncs, 0 embedded
`timescale 1ns/100ps
`default_nettype none
module ccf_capture_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic cam_pixel_clock,
  input wire logic cam_frame_sync,
  input wire logic cam_line_valid,
  input wire logic [7:0] cam_pixel_bus,
  output logic cam_master_clock_out,
  output logic cam_reset_out,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic frame_irq,
  output logic prv_wr_valid,
  output logic [31:0] prv_wr_data,
  output logic [1:0] prv_wr_buf,
  output logic [12:0] prv_wr_x,
  output logic [12:0] prv_wr_y,
  output logic cod_wr_valid,
  output logic [31:0] cod_wr_data,
  output logic [1:0] cod_wr_plane,
  output logic [1:0] cod_wr_buf,
  output logic [12:0] cod_wr_x,
  output logic [12:0] cod_wr_y
);
  import ccf_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [31:0] srcfmt_q;
  logic [31:0] gctrl_q;
  logic [CMD_W-1:0] cmd_pend_q;
  logic [CMD_W-1:0] cmd_act_q;
  logic [10:0] pin_s1_q;
  logic [10:0] pin_s2_q;
  logic pclk_prev_q;
  logic fs_prev_q;
  logic lv_prev_q;
  logic [1:0] mclk_cnt_q;
  logic fs_emb_q;
  logic lv_emb_q;
  logic field_q;
  logic [1:0] fcnt_q;
  logic [1:0] cur_buf_q;
  logic last_arm_q;
  logic covf_q;
  ccf_phase_e phase_q;
  logic [12:0] xcnt_q;
  logic [12:0] ycnt_q;
  logic [7:0] y0_q;
  logic [7:0] y1_q;
  logic [7:0] cb_q;
  logic [7:0] cr_q;
  logic pend_q;
  logic pclk_s;
  logic fs_s;
  logic lv_s;
  logic pix_stb;
  logic mode_601;
  logic frame_sync;
  logic line_act;
  logic fs_fall;
  logic fs_rise;
  logic soft_rst;
  logic capturing;
  logic cod_run;
  logic prv_run;
  logic [12:0] hs_eff;
  logic [12:0] vs_eff;
  logic [12:0] in_lim;
  logic [NUM_PLANES-1:0] pk_in;
  logic [NUM_PLANES-1:0] pk_out;
  logic [31:0] pk_word [NUM_PLANES];
  ccf_pix_if pix ();

  function automatic logic [12:0] mir_pos(input logic [12:0] pos,
                                          input logic [12:0] size,
                                          input logic flip);
    mir_pos = flip ? 13'(size - 13'd1 - pos) : pos;
  endfunction

  function automatic logic [15:0] rgb16(input logic [7:0] r,
                                        input logic [7:0] g,
                                        input logic [7:0] b);
    rgb16 = {r[7:3], g[7:2], b[7:3]};
  endfunction

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Pins come from the camera's timing: two stages before any use
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 11'h000;
      pin_s2_q <= 11'h000;
    end else begin
      pin_s1_q <= {cam_pixel_clock, cam_frame_sync, cam_line_valid,
                   cam_pixel_bus};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign pclk_s = pin_s2_q[10] ^ gctrl_q[GC_INV_PCLK];
  assign fs_s = pin_s2_q[9] ^ gctrl_q[GC_INV_FS];
  assign lv_s = pin_s2_q[8] ^ gctrl_q[GC_INV_LV];
  assign pix_stb = pclk_s && !pclk_prev_q;
  assign mode_601 = srcfmt_q[SRC_MODE_BIT];
  assign frame_sync = mode_601 ? fs_s : fs_emb_q;
  assign line_act = mode_601 ? lv_s : lv_emb_q;
  assign fs_fall = fs_prev_q && !frame_sync;
  assign fs_rise = !fs_prev_q && frame_sync;
  assign soft_rst = gctrl_q[GC_BLOCK_SOFT_RESET];
  assign capturing = cmd_act_q[CMD_GLOBAL];
  assign cod_run = capturing && cmd_act_q[CMD_CODEC];
  assign prv_run = capturing && cmd_act_q[CMD_PRV];
  assign in_lim = cmd_act_q[CMD_SCALE] ? MAX_SCALED : MAX_IN;
  assign hs_eff = (srcfmt_q[SRC_HS_LSB +: SIZE_W] > in_lim) ?
                  in_lim : srcfmt_q[SRC_HS_LSB +: SIZE_W];
  assign vs_eff = (srcfmt_q[SRC_VS_LSB +: SIZE_W] > in_lim) ?
                  in_lim : srcfmt_q[SRC_VS_LSB +: SIZE_W];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pclk_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
      lv_prev_q <= 1'b0;
    end else begin
      pclk_prev_q <= pclk_s;
      fs_prev_q <= frame_sync;
      lv_prev_q <= line_act;
    end
  end

  assign pix.px_data = pin_s2_q[7:0];
  assign pix.px_stb = pix_stb && !mode_601;

  ccf_sync_decoder u_dec (
    .clk (ref_clk),
    .rst_n (rst_n),
    .px (pix)
  );

  // Line stays open from SAV to EAV; a SAV only opens it outside field blanking
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_emb_q <= 1'b0;
      lv_emb_q <= 1'b0;
      field_q <= 1'b0;
    end else if (pix.code_stb) begin
      fs_emb_q <= pix.code_v;
      field_q <= pix.code_f;
      lv_emb_q <= !pix.code_h && !pix.code_v;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_cnt_q <= 2'h0;
      cam_master_clock_out <= 1'b0;
    end else if (mclk_cnt_q == MCLK_HALF) begin
      mclk_cnt_q <= 2'h0;
      cam_master_clock_out <= !cam_master_clock_out;
    end else begin
      mclk_cnt_q <= mclk_cnt_q + 2'h1;
    end
  end
  assign cam_reset_out = gctrl_q[GC_CAMRST];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      srcfmt_q <= SRCFMT_RST;
      gctrl_q <= GCTRL_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_SRCFMT) begin
        srcfmt_q <= reg_wdata;
      end
      if (reg_addr == ADDR_GCTRL) begin
        gctrl_q <= reg_wdata;
      end
    end
  end

  // Software writes only the pending copy; the active copy moves at
  // the frame sync fall so a frame never sees a half-written command
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_pend_q <= CMD_RST;
      cmd_act_q <= CMD_RST;
      last_arm_q <= 1'b0;
    end else if (soft_rst) begin
      cmd_act_q <= CMD_RST;
      last_arm_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_CMD) begin
        cmd_pend_q <= reg_wdata[CMD_W-1:0];
      end else if (fs_rise && last_arm_q) begin
        cmd_pend_q[CMD_LAST] <= 1'b0;
      end
      if (fs_fall) begin
        cmd_act_q <= cmd_pend_q;
        last_arm_q <= cmd_pend_q[CMD_LAST] && cmd_pend_q[CMD_GLOBAL];
      end else if (fs_rise && last_arm_q) begin
        last_arm_q <= 1'b0;
      end
    end
  end

  // Ordinary interrupt opens a frame; the armed last one fires at its frame sync rise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_irq <= 1'b0;
      fcnt_q <= 2'h0;
      cur_buf_q <= 2'h0;
    end else if (soft_rst) begin
      frame_irq <= 1'b0;
      fcnt_q <= 2'h0;
    end else begin
      frame_irq <= 1'b0;
      if ((fs_fall && cmd_pend_q[CMD_GLOBAL]) || (fs_rise && last_arm_q)) begin
        frame_irq <= 1'b1;
        fcnt_q <= fcnt_q + 2'h1;
      end
      if (fs_fall) begin
        cur_buf_q <= fcnt_q;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      covf_q <= 1'b0;
    end else if (prv_run && !cmd_act_q[CMD_CODEC] && line_act && pix_stb) begin
      covf_q <= 1'b1;
    end else if (reg_wr && reg_addr == ADDR_STATUS &&
                 reg_wdata[ST_CLR_COVF]) begin
      covf_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_SRCFMT: reg_rdata <= srcfmt_q;
          ADDR_GCTRL: reg_rdata <= gctrl_q;
          ADDR_CMD: reg_rdata <= 32'(cmd_pend_q);
          ADDR_STATUS: begin
            reg_rdata[ST_FS] <= frame_sync;
            reg_rdata[ST_FCNT_LSB +: 2] <= fcnt_q;
            reg_rdata[ST_FIELD] <= field_q;
            reg_rdata[ST_COVF] <= covf_q;
            reg_rdata[CMD_W-1:0] <= cmd_act_q;
          end
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Byte order fixed at Y0 Cb Y1 Cr
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_Y0;
      xcnt_q <= 13'h0000;
      ycnt_q <= 13'h0000;
      y0_q <= 8'h00;
      y1_q <= 8'h00;
      cb_q <= 8'h00;
      cr_q <= 8'h00;
    end else if (fs_fall || soft_rst) begin
      phase_q <= PH_Y0;
      xcnt_q <= 13'h0000;
      ycnt_q <= 13'h0000;
    end else if (lv_prev_q && !line_act) begin
      phase_q <= PH_Y0;
      xcnt_q <= 13'h0000;
      ycnt_q <= 13'(ycnt_q + 13'd1);
    end else if (pix_stb && line_act) begin
      case (phase_q)
        PH_Y0: begin
          y0_q <= pix.px_data;
          phase_q <= PH_CB;
        end
        PH_CB: begin
          cb_q <= pix.px_data;
          phase_q <= PH_Y1;
        end
        PH_Y1: begin
          y1_q <= pix.px_data;
          phase_q <= PH_CR;
        end
        default: begin
          cr_q <= pix.px_data;
          phase_q <= PH_Y0;
          xcnt_q <= 13'(xcnt_q + 13'd2);
        end
      endcase
    end
  end

  generate
    for (genvar i = 0; i < NUM_PLANES; i++) begin : g_plane
      ccf_word_packer u_pack (
        .clk (ref_clk),
        .rst_n (rst_n),
        .clear (fs_fall || soft_rst),
        .in_valid (pk_in[i]),
        .in_byte (pix.px_data),
        .out_valid (pk_out[i]),
        .out_word (pk_word[i])
      );
    end
  endgenerate

  // 4:2:0 drops chroma on odd lines; bytes past the size limit are lost
  always_comb begin
    pk_in = '0;
    if (cod_run && pix_stb && line_act && xcnt_q < hs_eff &&
        ycnt_q < vs_eff) begin
      pk_in[0] = phase_q == PH_Y0 || phase_q == PH_Y1;
      pk_in[1] = phase_q == PH_CB &&
                 !(cmd_act_q[CMD_C420] && ycnt_q[0]);
      pk_in[2] = phase_q == PH_CR &&
                 !(cmd_act_q[CMD_C420] && ycnt_q[0]);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cod_wr_valid <= 1'b0;
      cod_wr_data <= 32'h0000_0000;
      cod_wr_plane <= 2'h0;
      cod_wr_buf <= 2'h0;
      cod_wr_x <= 13'h0000;
      cod_wr_y <= 13'h0000;
    end else begin
      cod_wr_valid <= |pk_out;
      if (|pk_out) begin
        cod_wr_data <= pk_out[1] ? pk_word[1] :
                       pk_out[2] ? pk_word[2] : pk_word[0];
        cod_wr_plane <= pk_out[1] ? 2'h1 : pk_out[2] ? 2'h2 : 2'h0;
        cod_wr_buf <= cur_buf_q;
        cod_wr_x <= mir_pos(xcnt_q, hs_eff,
                            cmd_act_q[CMD_MIR_LSB+1]);
        cod_wr_y <= mir_pos(ycnt_q, vs_eff,
                            cmd_act_q[CMD_MIR_LSB]);
      end
    end
  end

  // Colour conversion belongs to the scaler; raw components map to RGB
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      prv_wr_valid <= 1'b0;
      prv_wr_data <= 32'h0000_0000;
      prv_wr_buf <= 2'h0;
      prv_wr_x <= 13'h0000;
      prv_wr_y <= 13'h0000;
    end else begin
      prv_wr_valid <= 1'b0;
      pend_q <= 1'b0;
      if (prv_run && pix_stb && line_act && phase_q == PH_CR &&
          xcnt_q < PRV_MAX_W && ycnt_q < PRV_MAX_H) begin
        prv_wr_valid <= 1'b1;
        prv_wr_buf <= cur_buf_q;
        prv_wr_x <= mir_pos(xcnt_q, PRV_MAX_W,
                            cmd_act_q[CMD_MIR_LSB+1]);
        prv_wr_y <= mir_pos(ycnt_q, PRV_MAX_H,
                            cmd_act_q[CMD_MIR_LSB]);
        if (cmd_act_q[CMD_RGB24]) begin
          prv_wr_data <= {8'h00, pix.px_data, y0_q, cb_q};
          pend_q <= 1'b1;
        end else begin
          prv_wr_data <= {rgb16(pix.px_data, y1_q, cb_q),
                          rgb16(pix.px_data, y0_q, cb_q)};
        end
      end else if (pend_q) begin
        prv_wr_valid <= 1'b1;
        prv_wr_data <= {8'h00, cr_q, y1_q, cb_q};
        prv_wr_x <= cmd_act_q[CMD_MIR_LSB+1] ?
                    13'(prv_wr_x - 13'd1) : 13'(prv_wr_x + 13'd1);
      end
    end
  end
endmodule
`default_nettype wire

// File: ccf_pix_if.sv
// Byte stream into the reference-code decoder and its decoded flags.
// Both ends run on ref_clk.
`timescale 1ns/100ps
`default_nettype none
interface ccf_pix_if;
  logic [7:0] px_data;
  logic px_stb;
  logic code_stb;
  logic code_f;
  logic code_v;
  logic code_h;
  modport cap (output px_data, output px_stb,
               input code_stb, input code_f, input code_v, input code_h);
  modport dec (input px_data, input px_stb,
               output code_stb, output code_f, output code_v, output code_h);
endinterface
`default_nettype wire

// File: ccf_pkg.sv
// Constants shared by the camera capture front end.
// Assumes a 20 MHz ref_clk and byte-wide register offsets.
package ccf_pkg;
  localparam logic [7:0] ADDR_SRCFMT = 8'h00;
  localparam logic [7:0] ADDR_GCTRL = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [31:0] SRCFMT_RST = 32'h0000_0000;
  localparam logic [31:0] GCTRL_RST = 32'h0000_0000;
  localparam logic [8:0] CMD_RST = 9'h000;
  localparam int SRC_MODE_BIT = 31;
  localparam int SRC_HS_LSB = 16;
  localparam int SRC_VS_LSB = 0;
  localparam int SIZE_W = 13;
  localparam int GC_BLOCK_SOFT_RESET = 31;
  localparam int GC_CAMRST = 30;
  localparam int GC_INV_PCLK = 26;
  localparam int GC_INV_FS = 25;
  localparam int GC_INV_LV = 24;
  localparam int CMD_W = 9;
  localparam int CMD_GLOBAL = 0;
  localparam int CMD_CODEC = 1;
  localparam int CMD_PRV = 2;
  localparam int CMD_LAST = 3;
  localparam int CMD_MIR_LSB = 4;
  localparam int CMD_RGB24 = 6;
  localparam int CMD_C420 = 7;
  localparam int CMD_SCALE = 8;
  localparam int ST_FS = 31;
  localparam int ST_FCNT_LSB = 26;
  localparam int ST_FIELD = 25;
  localparam int ST_COVF = 24;
  localparam int ST_CLR_COVF = 24;
  localparam logic [12:0] MAX_IN = 13'd4096;
  localparam logic [12:0] MAX_SCALED = 13'd2048;
  localparam logic [12:0] PRV_MAX_W = 13'd640;
  localparam logic [12:0] PRV_MAX_H = 13'd480;
  localparam logic [7:0] PRE_ONE = 8'hFF;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  localparam int XY_ONE = 7;
  localparam int XY_F = 6;
  localparam int XY_V = 5;
  localparam int XY_H = 4;
  localparam logic [1:0] MCLK_HALF = 2'h1;
  localparam int NUM_PLANES = 3;
  typedef enum logic [1:0] {PH_Y0, PH_CB, PH_Y1, PH_CR} ccf_phase_e;
  typedef enum logic [1:0] {DS_IDLE, DS_FF, DS_Z1, DS_Z2} ccf_dstate_e;
endpackage

// File: ccf_sync_decoder.sv
// Finds embedded timing reference codes in the sampled byte stream.
// Bytes arrive as one-cycle strobes on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module ccf_sync_decoder (
  input wire logic clk,
  input wire logic rst_n,
  ccf_pix_if.dec px
);
  import ccf_pkg::*;
  ccf_dstate_e st_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= DS_IDLE;
    end else if (px.px_stb) begin
      case (st_q)
        DS_FF: st_q <= (px.px_data == PRE_ZERO) ? DS_Z1 :
                       (px.px_data == PRE_ONE) ? DS_FF : DS_IDLE;
        DS_Z1: st_q <= (px.px_data == PRE_ZERO) ? DS_Z2 :
                       (px.px_data == PRE_ONE) ? DS_FF : DS_IDLE;
        default: st_q <= (px.px_data == PRE_ONE) ? DS_FF : DS_IDLE;
      endcase
    end
  end

  // Protection nibble is not checked; a bad code is rare and self-heals
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      px.code_stb <= 1'b0;
      px.code_f <= 1'b0;
      px.code_v <= 1'b0;
      px.code_h <= 1'b0;
    end else begin
      px.code_stb <= px.px_stb && st_q == DS_Z2 && px.px_data[XY_ONE];
      if (px.px_stb && st_q == DS_Z2) begin
        px.code_f <= px.px_data[XY_F];
        px.code_v <= px.px_data[XY_V];
        px.code_h <= px.px_data[XY_H];
      end
    end
  end
endmodule
`default_nettype wire

// File: ccf_word_packer.sv
// Packs bytes into 32-bit words, earliest byte in the low lane.
// Clear restarts the lane count at a frame boundary.
`timescale 1ns/100ps
`default_nettype none
module ccf_word_packer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  output logic out_valid,
  output logic [31:0] out_word
);
  logic [1:0] lane_q;
  logic [23:0] acc_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_q <= 2'h0;
      acc_q <= 24'h00_0000;
      out_valid <= 1'b0;
      out_word <= 32'h0000_0000;
    end else begin
      out_valid <= 1'b0;
      if (clear) begin
        lane_q <= 2'h0;
      end else if (in_valid) begin
        lane_q <= lane_q + 2'h1;
        if (lane_q == 2'h3) begin
          out_word <= {in_byte, acc_q};
          out_valid <= 1'b1;
        end else begin
          acc_q[8*lane_q +: 8] <= in_byte;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb_camera_capture_frontend.sv
// Self-checking bench for the capture front end.
// Registers are driven on ref_clk; the camera model supplies frames.
`timescale 1ns/100ps
`default_nettype none
module tb_camera_capture_frontend;
  import ccf_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cam_pixel_clock, cam_frame_sync, cam_line_valid;
  logic [7:0] cam_pixel_bus;
  logic cam_master_clock_out, cam_reset_out, frame_irq;
  logic prv_wr_valid, cod_wr_valid;
  logic [31:0] reg_rdata, prv_wr_data, cod_wr_data;
  logic [1:0] prv_wr_buf, cod_wr_plane, cod_wr_buf;
  logic [12:0] prv_wr_x, prv_wr_y, cod_wr_x, cod_wr_y;
  int failures = 0;
  int total_checks = 0;
  int irqs = 0;
  int cwords = 0;
  int cw0 = 0;
  logic got_c = 1'b0;
  logic got_p = 1'b0;
  logic [31:0] c_word, p_word, p_last, v;
  logic [1:0] c_plane, c_buf, p_buf;
  logic [12:0] p_x;
  always #25 ref_clk = ~ref_clk;
  ccf_cam_model i_cam (.cam_pixel_clock, .cam_frame_sync, .cam_line_valid,
    .cam_pixel_bus);
  ccf_capture_top i_ccf_capture_top (.ref_clk, .rstn, .cam_pixel_clock,
    .cam_frame_sync, .cam_line_valid, .cam_pixel_bus, .cam_master_clock_out,
    .cam_reset_out, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .frame_irq, .prv_wr_valid, .prv_wr_data, .prv_wr_buf, .prv_wr_x,
    .prv_wr_y, .cod_wr_valid, .cod_wr_data, .cod_wr_plane, .cod_wr_buf,
    .cod_wr_x, .cod_wr_y);
  // Keep the first word of each path and the latest preview word; later words mix in preamble
  always @(posedge ref_clk) begin
    if (frame_irq) irqs <= irqs + 1;
    if (cod_wr_valid) cwords <= cwords + 1;
    if (cod_wr_valid) c_buf <= cod_wr_buf;
    if (prv_wr_valid) begin
      p_last <= prv_wr_data;
      p_buf <= prv_wr_buf;
      p_x <= prv_wr_x;
    end
    if (cod_wr_valid && !got_c) begin
      got_c <= 1'b1;
      c_word <= cod_wr_data;
      c_plane <= cod_wr_plane;
    end
    if (prv_wr_valid && !got_p) begin
      got_p <= 1'b1;
      p_word <= prv_wr_data;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input string what, input logic [7:0] a,
                    input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rc("srcfmt reset", ADDR_SRCFMT, SRCFMT_RST);
    rc("gctrl reset", ADDR_GCTRL, GCTRL_RST);
    wr(ADDR_GCTRL, 32'h4000_0000);
    rc("gctrl readback", ADDR_GCTRL, 32'h4000_0000);
    chk("camera reset pin", 32'h1, 32'(cam_reset_out));
    wr(ADDR_GCTRL, 32'h0);
    wr(8'h04, 32'hFFFF_FFFF);
    rc("unmapped read", 8'h04, 32'h0);
    $display("test registers done");
    wr(ADDR_SRCFMT, 32'h0010_0008);
    i_cam.frame(1'b1, 1'b0);
    // Pipeline flush: sync stages plus packer and output register
    repeat (8) @(posedge ref_clk);
    chk("irq while disabled", 32'h0, 32'(irqs));
    chk("codec word while disabled", 32'h0, 32'(got_c));
    wr(ADDR_CMD, 32'h47);
    i_cam.frame(1'b1, 1'b0);
    repeat (8) @(posedge ref_clk);
    chk("irq count", 32'h1, 32'(irqs));
    chk("codec luma word", 32'h1614_1210, c_word);
    chk("codec plane", 32'h0, 32'(c_plane));
    chk("rgb24 word", 32'h0013_1011, p_word);
    rd(ADDR_STATUS, v);
    chk("frame counter", 32'h1, 32'(v[27:26]));
    $display("test embedded sync done");
    wr(ADDR_GCTRL, 32'h0100_0000);
    wr(ADDR_SRCFMT, 32'h8010_0008);
    wr(ADDR_CMD, 32'h0F);
    cw0 = cwords;
    i_cam.frame(1'b0, 1'b1);
    repeat (8) @(posedge ref_clk);
    chk("irq count last", 32'h3, 32'(irqs));
    chk("codec words", 32'h1, 32'(cwords - cw0));
    chk("codec buffer", 32'h1, 32'(c_buf));
    chk("preview buffer", 32'h1, 32'(p_buf));
    chk("rgb16 word", 32'h10A2_10A2, p_last);
    rc("last enable cleared", ADDR_CMD, 32'h07);
    rd(ADDR_STATUS, v);
    chk("frame counter step", 32'h3, 32'(v[27:26]));
    chk("frame sync level", 32'h1, 32'(v[31]));
    $display("test separate sync done");
    // Preview alone, mirrored in X: overflow must rise, then clear
    wr(ADDR_CMD, 32'h65);
    i_cam.frame(1'b0, 1'b1);
    repeat (8) @(posedge ref_clk);
    chk("mirrored x", 32'h0000_027C, 32'(p_x));
    rd(ADDR_STATUS, v);
    chk("codec overflow", 32'h1, 32'(v[24]));
    wr(ADDR_STATUS, 32'h0100_0000);
    rd(ADDR_STATUS, v);
    chk("overflow cleared", 32'h0, 32'(v[24]));
    $display("test overflow done");
    report_and_stop();
  end
  initial begin
    #500000;
    failures++;
    $display("unexpected watchdog: expected end seen timeout");
    report_and_stop();
  end
endmodule
`default_nettype wire
